//--- src/buck_cfg_pkg.sv
// Purpose: Shared constants and types for the buck application configuration bank
// Assumes: 100 MHz internal clock, 8-bit registers at 9-bit offsets
// Notes:   Reset values are plain zero defaults
//
// How it works
// - Lockout-disable bit 7 turns off the I/O rail lockout and comparator.
// - Buck B good-power output holds its last value during ramps when masked.
// - Buck A good-power output holds its last value during ramps when masked.
// - Buck B overcurrent field: 00 never masks, else ramp plus 2/10/50 us.
// - Buck A overcurrent field uses the same encoding as buck B.
// - Reload bit lets input-configured general pin zero trigger a fuse reload.
// - Pull bits 0, 1, 4 enable pull-downs on input pins zero, one, four.
// - Pull bits 2, 3: pull-down as input, pull-up as open-drain output.
// - Bits 7:6 route buck B good-power: none, pin two, pin three, reserved.
// - Bits 5:4 route buck A good-power: none, pin two, pin three, reserved.
// - Bits 3:2 route buck B ready: none, pin two, pin three, reserved.
// - Bits 1:0 route buck A ready: none, pin two, pin three, reserved.
// - Role bit 7: zero means companion, one means stand-alone.
// - Trim bits 2:0 raise oscillator by 180 kHz per step.
// - Address bits 7:4 give the second bus address upper nibble.
// - Upper nibble 0000 means unprogrammed: use hardware default address.
// - Select field picks no pin, input pin zero, one or four.
// - Address register bits 3:2 are read-only; writes do nothing.

package buck_cfg_pkg;

  // Register offsets
  localparam logic [8:0] PROTECT_MASK_OFS  = 9'h144;
  localparam logic [8:0] PIN_PULL_OFS      = 9'h145;
  localparam logic [8:0] SIGNAL_ROUTE_OFS  = 9'h146;
  localparam logic [8:0] ROLE_OSC_OFS      = 9'h147;
  localparam logic [8:0] ALT_ADDRESS_OFS   = 9'h148;

  // Reset values
  localparam logic [7:0] PROTECT_MASK_RST  = 8'h00;
  localparam logic [7:0] PIN_PULL_RST      = 8'h00;
  localparam logic [7:0] SIGNAL_ROUTE_RST  = 8'h00;
  localparam logic [7:0] ROLE_OSC_RST      = 8'h00;
  localparam logic [7:0] ALT_ADDRESS_RST   = 8'h00;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;

  // Field positions
  localparam int LOCKOUT_DIS_BIT = 7;
  localparam int ROLE_BIT        = 7;
  localparam int PULL_IN0_BIT    = 0;
  localparam int PULL_IN1_BIT    = 1;
  localparam int PULL_IO2_BIT    = 2;
  localparam int PULL_IO3_BIT    = 3;
  localparam int PULL_IN4_BIT    = 4;
  localparam logic [7:0] ALT_ADDRESS_WMASK = 8'hF3;

  // Route codes for pin two and pin three
  localparam logic [1:0] ROUTE_NONE  = 2'h0;
  localparam logic [1:0] ROUTE_PIN2  = 2'h1;
  localparam logic [1:0] ROUTE_PIN3  = 2'h2;

  // Alternative address pin selection codes
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_IN0  = 2'h1;
  localparam logic [1:0] SEL_IN1  = 2'h2;
  localparam logic [1:0] SEL_IN4  = 2'h3;
  localparam logic [3:0] ADDR_UNPROGRAMMED = 4'h0;

  // Holdoff timing
  localparam int CLK_MHZ       = 100;
  localparam int HOLD_SHORT_US = 2;
  localparam int HOLD_MID_US   = 10;
  localparam int HOLD_LONG_US  = 50;
  localparam int HOLD_SHORT_CYC = HOLD_SHORT_US * CLK_MHZ;
  localparam int HOLD_MID_CYC   = HOLD_MID_US * CLK_MHZ;
  localparam int HOLD_LONG_CYC  = HOLD_LONG_US * CLK_MHZ;
  localparam int TRIM_STEP_KHZ  = 180;

  // Protection and masking register layout
  typedef struct packed {
    logic       lockout_disable;
    logic       buck_b_goodpower_ramp_mask;
    logic       buck_a_goodpower_ramp_mask;
    logic [1:0] buck_b_overcurrent_holdoff;
    logic [1:0] buck_a_overcurrent_holdoff;
    logic       fuse_reload_pin_enable;
  } protect_mask_t;

  // Routing register layout
  typedef struct packed {
    logic [1:0] buck_b_goodpower_route;
    logic [1:0] buck_a_goodpower_route;
    logic [1:0] buck_b_ready_route;
    logic [1:0] buck_a_ready_route;
  } signal_route_t;

endpackage : buck_cfg_pkg

//--- src/overcurrent_holdoff.sv
// Purpose: Masks overcurrent events during a ramp and for a coded extra time
// Assumes: ramp level comes from logic on the same clock
// Notes:   A nonzero code change mid-count takes effect at the next ramp end; code zero unmasks at once
`timescale 1ns/10ps
module overcurrent_holdoff #(
  parameter int HOLD_SHORT = buck_cfg_pkg::HOLD_SHORT_CYC,
  parameter int HOLD_MID   = buck_cfg_pkg::HOLD_MID_CYC,
  parameter int HOLD_LONG  = buck_cfg_pkg::HOLD_LONG_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] holdoff_code,
  input  wire logic       ramp_active,
  output logic            mask_active
);
  // Counter fits the longest of the three counts, whichever that is
  localparam int HOLD_SM  = (HOLD_MID > HOLD_SHORT) ? HOLD_MID : HOLD_SHORT;
  localparam int HOLD_MAX = (HOLD_LONG > HOLD_SM) ? HOLD_LONG : HOLD_SM;
  localparam int CW = $clog2(HOLD_MAX + 1);

  initial
  begin
    if (HOLD_SHORT < 1 || HOLD_MID < 1 || HOLD_LONG < 1)
      $error("holdoff counts must be at least one cycle");
  end

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic          ramp_d_reg;
  logic [CW-1:0] load_value;
  wire           ramp_end = ramp_d_reg & ~ramp_active;

  // Load value per holdoff code
  assign load_value = (holdoff_code == 2'h1) ? CW'(HOLD_SHORT) :
                      (holdoff_code == 2'h2) ? CW'(HOLD_MID) :
                      (holdoff_code == 2'h3) ? CW'(HOLD_LONG) : '0;

  assign count_next = ramp_active ? '0 :
                      ramp_end ? load_value :
                      (count_reg != '0) ? count_reg - 1'b1 : count_reg;

  // mask during ramp plus extra time
  assign mask_active = (holdoff_code != 2'h0) & (ramp_active | ramp_d_reg | (count_reg != '0));

  // Count register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_reg  <= '0;
      ramp_d_reg <= 1'b0;
    end
    else
    begin
      count_reg  <= count_next;
      ramp_d_reg <= ramp_active;
    end
  end
endmodule : overcurrent_holdoff

//--- src/pin_router.sv
// Purpose: Routes good-power and ready signals onto output pins two and three
// Assumes: Reserved route code drives nothing
// Notes:   Several sources on one pin are OR-combined
`timescale 1ns/10ps
module pin_router (
  input  wire logic                        route_en,
  input  wire buck_cfg_pkg::signal_route_t routes,
  input  wire logic                        good_a,
  input  wire logic                        good_b,
  input  wire logic                        ready_a,
  input  wire logic                        ready_b,
  output logic                             pin_two_level,
  output logic                             pin_three_level
);
  logic [1:0] code_vec [4];
  logic [3:0] src_vec;
  logic [3:0] to_two;
  logic [3:0] to_three;

  assign code_vec[0] = routes.buck_b_goodpower_route;
  assign code_vec[1] = routes.buck_a_goodpower_route;
  assign code_vec[2] = routes.buck_b_ready_route;
  assign code_vec[3] = routes.buck_a_ready_route;
  assign src_vec     = {ready_a, ready_b, good_a, good_b};

  for (genvar i = 0; i < 4; i++)
  begin : g_route
    assign to_two[i]   = src_vec[i] & (code_vec[i] == buck_cfg_pkg::ROUTE_PIN2);
    assign to_three[i] = src_vec[i] & (code_vec[i] == buck_cfg_pkg::ROUTE_PIN3);
  end

  assign pin_two_level   = route_en & (|to_two);
  assign pin_three_level = route_en & (|to_three);
endmodule : pin_router

//--- src/buck_app_config_bank.sv
// Purpose: Application configuration register bank and the logic it steers
// Assumes: Register port is driven by the serial interface on the same clock
// Notes:   Analog and pin inputs are synchronised before use
`timescale 1ns/10ps
module buck_app_config_bank #(
  parameter logic [3:0] DEFAULT_ADDRESS_HIGH = 4'hD,
  parameter int         HOLD_LONG          = buck_cfg_pkg::HOLD_LONG_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [8:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  input  wire logic       ramp_a,
  input  wire logic       ramp_b,
  input  wire logic       ready_a,
  input  wire logic       ready_b,
  input  wire logic       goodpower_a_raw,
  input  wire logic       goodpower_b_raw,
  input  wire logic       overcurrent_a_raw,
  input  wire logic       overcurrent_b_raw,
  input  wire logic       io_rail_low_raw,
  input  wire logic       input_pin_zero,
  input  wire logic       input_pin_one,
  input  wire logic       input_pin_four,
  input  wire logic       general_pin_zero,
  input  wire logic       general_pin_zero_is_input,
  input  wire logic       io2_is_output,
  input  wire logic       io3_is_output,
  output logic            io_rail_comparator_on,
  output logic            io_rail_lockout,
  output logic            goodpower_a,
  output logic            goodpower_b,
  output logic            overcurrent_event_a,
  output logic            overcurrent_event_b,
  output logic            fuse_reload_req,
  output logic [2:0]      input_pulldown_en,
  output logic [1:0]      io_pulldown_en,
  output logic [1:0]      io_pullup_en,
  output logic            output_pin_two,
  output logic            output_pin_three,
  output logic            stand_alone,
  output logic [2:0]      oscillator_trim,
  output logic [3:0]      bus_address_high
);
  localparam int NSYNC = 9;

  initial
  begin
    if (HOLD_LONG < 1)
      $error("HOLD_LONG must be at least one cycle");
  end

  logic [1:0]       rst_sync_reg;
  wire              rst_int_b = rst_sync_reg[1];
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] async_in;
  logic [7:0]       protect_reg;
  logic [7:0]       pull_reg;
  logic [7:0]       route_reg;
  logic [7:0]       role_osc_reg;
  logic [7:0]       alt_addr_reg;
  logic             pin_zero_d_reg;

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  // Two-stage synchronisers for pins and analog comparators
  assign async_in = {general_pin_zero, input_pin_four, input_pin_one, input_pin_zero,
                     io_rail_low_raw, overcurrent_b_raw, overcurrent_a_raw,
                     goodpower_b_raw, goodpower_a_raw};
  always_ff @(posedge clk or negedge rst_int_b)
  begin
    if (!rst_int_b)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end

  wire pg_a_s   = sync2_reg[0];
  wire pg_b_s   = sync2_reg[1];
  wire oc_a_s   = sync2_reg[2];
  wire oc_b_s   = sync2_reg[3];
  wire rail_low = sync2_reg[4];
  wire in0_s    = sync2_reg[5];
  wire in1_s    = sync2_reg[6];
  wire in4_s    = sync2_reg[7];
  wire gp0_s    = sync2_reg[8];

  // Register write decode
  wire wr_protect = reg_wr & (reg_addr == buck_cfg_pkg::PROTECT_MASK_OFS);
  wire wr_pull    = reg_wr & (reg_addr == buck_cfg_pkg::PIN_PULL_OFS);
  wire wr_route   = reg_wr & (reg_addr == buck_cfg_pkg::SIGNAL_ROUTE_OFS);
  wire wr_role    = reg_wr & (reg_addr == buck_cfg_pkg::ROLE_OSC_OFS);
  wire wr_alt     = reg_wr & (reg_addr == buck_cfg_pkg::ALT_ADDRESS_OFS);

  // read-only reserved bits masked on write
  wire [7:0] alt_addr_next = reg_wdata & buck_cfg_pkg::ALT_ADDRESS_WMASK;

  // Register storage
  always_ff @(posedge clk or negedge rst_int_b)
  begin
    if (!rst_int_b)
    begin
      protect_reg  <= buck_cfg_pkg::PROTECT_MASK_RST;
      pull_reg     <= buck_cfg_pkg::PIN_PULL_RST;
      route_reg    <= buck_cfg_pkg::SIGNAL_ROUTE_RST;
      role_osc_reg <= buck_cfg_pkg::ROLE_OSC_RST;
      alt_addr_reg <= buck_cfg_pkg::ALT_ADDRESS_RST;
    end
    else
    begin
      if (wr_protect) protect_reg  <= reg_wdata;
      if (wr_pull)    pull_reg     <= reg_wdata;
      if (wr_route)   route_reg    <= reg_wdata;
      if (wr_role)    role_osc_reg <= reg_wdata;
      if (wr_alt)     alt_addr_reg <= alt_addr_next;
    end
  end

  // Read data select; unmapped offsets read as zero
  wire [7:0] rdata_next =
    (reg_addr == buck_cfg_pkg::PROTECT_MASK_OFS) ? protect_reg :
    (reg_addr == buck_cfg_pkg::PIN_PULL_OFS)     ? pull_reg :
    (reg_addr == buck_cfg_pkg::SIGNAL_ROUTE_OFS) ? route_reg :
    (reg_addr == buck_cfg_pkg::ROLE_OSC_OFS)     ? role_osc_reg :
    (reg_addr == buck_cfg_pkg::ALT_ADDRESS_OFS)  ? alt_addr_reg :
    buck_cfg_pkg::UNMAPPED_READ;

  always_ff @(posedge clk or negedge rst_int_b)
  begin
    if (!rst_int_b)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_next;
  end

  buck_cfg_pkg::protect_mask_t pm;
  assign pm = buck_cfg_pkg::protect_mask_t'(protect_reg);

  // Overcurrent holdoff per buck
  logic oc_mask_a;
  logic oc_mask_b;
  overcurrent_holdoff #(
    .HOLD_SHORT (buck_cfg_pkg::HOLD_SHORT_CYC),
    .HOLD_MID   (buck_cfg_pkg::HOLD_MID_CYC),
    .HOLD_LONG  (HOLD_LONG)
  ) u_hold_a (
    .clk          (clk),
    .rst_b        (rst_int_b),
    .holdoff_code (pm.buck_a_overcurrent_holdoff),
    .ramp_active  (ramp_a),
    .mask_active  (oc_mask_a)
  );
  overcurrent_holdoff #(
    .HOLD_SHORT (buck_cfg_pkg::HOLD_SHORT_CYC),
    .HOLD_MID   (buck_cfg_pkg::HOLD_MID_CYC),
    .HOLD_LONG  (HOLD_LONG)
  ) u_hold_b (
    .clk          (clk),
    .rst_b        (rst_int_b),
    .holdoff_code (pm.buck_b_overcurrent_holdoff),
    .ramp_active  (ramp_b),
    .mask_active  (oc_mask_b)
  );

  // freeze good-power while ramping and masked
  wire hold_pg_a = ramp_a & pm.buck_a_goodpower_ramp_mask;
  wire hold_pg_b = ramp_b & pm.buck_b_goodpower_ramp_mask;
  wire pg_a_next = hold_pg_a ? goodpower_a : pg_a_s;
  wire pg_b_next = hold_pg_b ? goodpower_b : pg_b_s;

  // reload on rising edge of input-configured pin zero
  wire reload_next = pm.fuse_reload_pin_enable & general_pin_zero_is_input &
                     gp0_s & ~pin_zero_d_reg;

  wire [2:0] in_pd_next = {pull_reg[buck_cfg_pkg::PULL_IN4_BIT],
                           pull_reg[buck_cfg_pkg::PULL_IN1_BIT],
                           pull_reg[buck_cfg_pkg::PULL_IN0_BIT]};
  wire [1:0] io_pull    = {pull_reg[buck_cfg_pkg::PULL_IO3_BIT],
                           pull_reg[buck_cfg_pkg::PULL_IO2_BIT]};
  wire [1:0] io_out     = {io3_is_output, io2_is_output};
  wire [1:0] io_pd_next = io_pull & ~io_out;
  wire [1:0] io_pu_next = io_pull & io_out;

  // Routing onto the output pins
  logic pin_two_next;
  logic pin_three_next;
  pin_router u_router (
    .route_en        (1'b1),
    .routes          (buck_cfg_pkg::signal_route_t'(route_reg)),
    .good_a          (goodpower_a),
    .good_b          (goodpower_b),
    .ready_a         (ready_a),
    .ready_b         (ready_b),
    .pin_two_level   (pin_two_next),
    .pin_three_level (pin_three_next)
  );

  wire [1:0] sel_code = alt_addr_reg[1:0];
  wire       alt_pin  = (sel_code == buck_cfg_pkg::SEL_IN0) ? in0_s :
                        (sel_code == buck_cfg_pkg::SEL_IN1) ? in1_s :
                        (sel_code == buck_cfg_pkg::SEL_IN4) ? in4_s : 1'b0;
  // unprogrammed nibble falls back to the default
  wire [3:0] second_bus_address_high = alt_addr_reg[7:4];
  wire       alt_ok   = second_bus_address_high != buck_cfg_pkg::ADDR_UNPROGRAMMED;
  wire [3:0] addr_next = (alt_pin & alt_ok) ? second_bus_address_high : DEFAULT_ADDRESS_HIGH;

  wire lockout_on = ~protect_reg[buck_cfg_pkg::LOCKOUT_DIS_BIT];

  // Registered outputs
  always_ff @(posedge clk or negedge rst_int_b)
  begin
    if (!rst_int_b)
    begin
      io_rail_comparator_on <= 1'b1;
      io_rail_lockout       <= 1'b0;
      goodpower_a           <= 1'b0;
      goodpower_b           <= 1'b0;
      overcurrent_event_a   <= 1'b0;
      overcurrent_event_b   <= 1'b0;
      fuse_reload_req       <= 1'b0;
      pin_zero_d_reg        <= 1'b0;
      input_pulldown_en     <= 3'h0;
      io_pulldown_en        <= 2'h0;
      io_pullup_en          <= 2'h0;
      output_pin_two        <= 1'b0;
      output_pin_three      <= 1'b0;
      stand_alone           <= 1'b0;
      oscillator_trim       <= 3'h0;
      bus_address_high      <= DEFAULT_ADDRESS_HIGH;
    end
    else
    begin
      io_rail_comparator_on <= lockout_on;
      io_rail_lockout       <= lockout_on & rail_low;
      goodpower_a           <= pg_a_next;
      goodpower_b           <= pg_b_next;
      overcurrent_event_a   <= oc_a_s & ~oc_mask_a;
      overcurrent_event_b   <= oc_b_s & ~oc_mask_b;
      fuse_reload_req       <= reload_next;
      pin_zero_d_reg        <= gp0_s;
      input_pulldown_en     <= in_pd_next;
      io_pulldown_en        <= io_pd_next;
      io_pullup_en          <= io_pu_next;
      output_pin_two        <= pin_two_next;
      output_pin_three      <= pin_three_next;
      // role bit straight to the role output
      stand_alone           <= role_osc_reg[buck_cfg_pkg::ROLE_BIT];
      // trim code passed on, code 101 unchecked
      oscillator_trim       <= role_osc_reg[2:0];
      bus_address_high      <= addr_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_int_b);

  lockout_disable_a: assert property (
    protect_reg[7] |=> !io_rail_comparator_on && !io_rail_lockout)
    else $error("lockout active while disabled");
  pg_b_hold_a: assert property (
    hold_pg_b |=> goodpower_b == $past(goodpower_b))
    else $error("buck B good-power moved during masked ramp");
  pg_a_hold_a: assert property (
    hold_pg_a |=> $stable(goodpower_a))
    else $error("buck A good-power moved during masked ramp");
  oc_b_ramp_a: assert property (
    (ramp_b && pm.buck_b_overcurrent_holdoff != 2'h0) |=> !overcurrent_event_b)
    else $error("buck B event not masked during ramp");
  oc_a_short_a: assert property (
    ($fell(ramp_a) && pm.buck_a_overcurrent_holdoff == 2'h1) ##1
    $stable(pm.buck_a_overcurrent_holdoff)[*8] |-> oc_mask_a)
    else $error("buck A holdoff released early");
  oc_never_a: assert property (
    (pm.buck_a_overcurrent_holdoff == 2'h0 && oc_a_s) |=> overcurrent_event_a)
    else $error("buck A event masked with code zero");
  reload_gate_a: assert property (
    fuse_reload_req |-> $past(pm.fuse_reload_pin_enable) && $past(general_pin_zero_is_input))
    else $error("reload without enable");
  pull_io_a: assert property (
    ##1 (io_pullup_en & io_pulldown_en) == 2'h0)
    else $error("pull-up and pull-down both on");
  pull_in_a: assert property (
    ##1 input_pulldown_en == $past(in_pd_next))
    else $error("input pull-down not following register");
  route_pin2_a: assert property (
    (route_reg[7:6] == 2'h1 && route_reg[5:4] != 2'h1 && route_reg[3:2] != 2'h1 &&
     route_reg[1:0] != 2'h1) |=> output_pin_two == $past(goodpower_b))
    else $error("buck B good-power not on pin two");
  addr_default_a: assert property (
    (alt_addr_reg[7:4] == 4'h0) |=> bus_address_high == DEFAULT_ADDRESS_HIGH)
    else $error("unprogrammed address not defaulted");
  addr_reserved_a: assert property (
    alt_addr_reg[3:2] == 2'h0)
    else $error("reserved address bits set");

  // Steered outputs, address and buck B middle holdoff
  lockout_on_a: assert property (
    (!protect_reg[7] && rail_low) |=> io_rail_lockout)
    else $error("lockout missing with rail low");
  pg_a_route_a: assert property (
    (route_reg[5:4] == 2'h2 && route_reg[7:6] != 2'h2 && route_reg[3:2] != 2'h2 &&
     route_reg[1:0] != 2'h2) |=> output_pin_three == $past(goodpower_a))
    else $error("buck A good-power not on pin three");
  role_out_a: assert property (
    ##1 stand_alone == $past(role_osc_reg[7]))
    else $error("role output not following register");
  trim_out_a: assert property (
    ##1 oscillator_trim == $past(role_osc_reg[2:0]))
    else $error("trim output not following register");
  addr_alt_a: assert property (
    (alt_addr_reg[1:0] == 2'h1 && in0_s && alt_addr_reg[7:4] != 4'h0) |=>
    bus_address_high == $past(alt_addr_reg[7:4]))
    else $error("second address not used");
  addr_nopin_a: assert property (
    (alt_addr_reg[1:0] == 2'h0) |=> bus_address_high == DEFAULT_ADDRESS_HIGH)
    else $error("address moved with no select pin");
  oc_b_mid_a: assert property (
    ($fell(ramp_b) && pm.buck_b_overcurrent_holdoff == 2'h2) ##1
    $stable(pm.buck_b_overcurrent_holdoff)[*8] |-> oc_mask_b)
    else $error("buck B holdoff released early");
endmodule : buck_app_config_bank

//--- test/host_model.sv
// Purpose: Host side of the register port, issuing single-byte accesses
// Assumes: Requests start on a falling edge and are taken at the next rising edge
// Notes:   Idle address and data are inverted so stale values never match by luck
`timescale 1ns/10ps
module host_model (
  input  wire logic       clk,
  output logic [8:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr  = 9'h000;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One write strobe held across a single rising edge, then released
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  // Read data is registered at the strobe edge and holds, so take it after
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask : rd
endmodule : host_model

//--- test/buck_app_config_bank_test.sv
// Purpose: Self-checking bench for the configuration bank and its steered outputs
// Assumes: Pins change at falling edges; sync and output stages settle in 6 cycles
// Notes:   Long holdoff shortened to HL cycles to keep the run brief
`timescale 1ns/10ps
module buck_app_config_bank_test;
  localparam int         HL  = 40;
  localparam logic [3:0] DEF = 4'hD;
  localparam logic [8:0] PM  = buck_cfg_pkg::PROTECT_MASK_OFS;
  localparam logic [8:0] ALT = buck_cfg_pkg::ALT_ADDRESS_OFS;
  localparam int         HS  = buck_cfg_pkg::HOLD_SHORT_CYC;
  localparam int         HM  = buck_cfg_pkg::HOLD_MID_CYC;
  logic        clk, rst_b, ramp_a, ramp_b, ready_a, ready_b, pg_a, pg_b, oc_a, oc_b;
  logic        rail_low, in0, in1, in4, gp0, gp0_in, io2_out, io3_out, seen_reload;
  logic        reg_wr, reg_rd, comp_on, lockout, good_a, good_b, ev_a, ev_b, reload;
  logic        pin2, pin3, alone;
  logic [8:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rd;
  logic [2:0]  in_pd, trim;
  logic [1:0]  io_pd, io_pu;
  logic [3:0]  addr_hi;
  logic [24:0] rows [6];
  int          n_fail, total_checks, cnt;

  buck_app_config_bank #(.DEFAULT_ADDRESS_HIGH(DEF), .HOLD_LONG(HL)) u_buck_app_config_bank (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ramp_a(ramp_a),
    .ramp_b(ramp_b), .ready_a(ready_a), .ready_b(ready_b), .goodpower_a_raw(pg_a),
    .goodpower_b_raw(pg_b), .overcurrent_a_raw(oc_a), .overcurrent_b_raw(oc_b),
    .io_rail_low_raw(rail_low), .input_pin_zero(in0), .input_pin_one(in1),
    .input_pin_four(in4), .general_pin_zero(gp0), .general_pin_zero_is_input(gp0_in),
    .io2_is_output(io2_out), .io3_is_output(io3_out), .io_rail_comparator_on(comp_on),
    .io_rail_lockout(lockout), .goodpower_a(good_a), .goodpower_b(good_b),
    .overcurrent_event_a(ev_a), .overcurrent_event_b(ev_b), .fuse_reload_req(reload),
    .input_pulldown_en(in_pd), .io_pulldown_en(io_pd), .io_pullup_en(io_pu),
    .output_pin_two(pin2), .output_pin_three(pin3), .stand_alone(alone),
    .oscillator_trim(trim), .bus_address_high(addr_hi));

  host_model u_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Reload request is a single-cycle pulse, so latch it for later checking
  always @(posedge clk)
    if (!rst_b)
      seen_reload <= 1'b0;
    else if (reload === 1'b1)
      seen_reload <= 1'b1;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic settle;
    repeat (6) @(negedge clk);
  endtask : settle

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  initial
  begin
    {ramp_a, ramp_b, ready_a, ready_b, pg_a, pg_b, oc_a, oc_b} = 8'h00;
    {rail_low, in0, in1, in4, gp0, gp0_in, io2_out, io3_out} = 8'h00;
    {n_fail, total_checks, rst_b} = '0;
    // Rows: offset, write value, expected read-back (last row is unmapped)
    rows = '{{PM, 8'hA5, 8'hA5}, {buck_cfg_pkg::PIN_PULL_OFS, 8'hFF, 8'hFF},
             {buck_cfg_pkg::SIGNAL_ROUTE_OFS, 8'hE4, 8'hE4},
             {buck_cfg_pkg::ROLE_OSC_OFS, 8'h87, 8'h87}, {ALT, 8'hFF, 8'hF3},
             {9'h149, 8'h55, 8'h00}};
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    chk({7'h00, comp_on}, 8'h01);
    chk({4'h0, addr_hi}, {4'h0, DEF});
    foreach (rows[i])
    begin
      u_host_model.rd(rows[i][24:16], rd);
      chk(rd, 8'h00);
      u_host_model.wr(rows[i][24:16], rows[i][15:8]);
      u_host_model.rd(rows[i][24:16], rd);
      chk(rd, rows[i][7:0]);
    end
    // Pulls: io2 as open-drain output, io3 as input
    io2_out = 1'b1;
    settle;
    chk({1'b0, in_pd, io_pd, io_pu}, 8'h79);
    chk({alone, 4'h0, trim}, 8'h87);
    u_host_model.wr(buck_cfg_pkg::PIN_PULL_OFS, 8'h00);
    u_host_model.wr(buck_cfg_pkg::ROLE_OSC_OFS, 8'h05);
    settle;
    chk({1'b0, in_pd, io_pd, io_pu}, 8'h00);
    chk({alone, 4'h0, trim}, 8'h05);
    // Routing: B good to pin two, A good to pin three, B ready reserved
    u_host_model.wr(buck_cfg_pkg::SIGNAL_ROUTE_OFS, 8'h6C);
    {pg_b, ready_b, ready_a} = 3'b111;
    settle;
    chk({6'h00, pin3, pin2}, 8'h01);
    {pg_a, pg_b} = 2'b10;
    settle;
    chk({6'h00, pin3, pin2}, 8'h02);
    u_host_model.wr(buck_cfg_pkg::SIGNAL_ROUTE_OFS, 8'hE4);
    settle;
    chk({6'h00, pin3, pin2}, 8'h03);
    // Each pin select code 1 to 3, its pin low then high
    for (int s = 1; s < 4; s++)
    begin
      u_host_model.wr(ALT, {6'h0C, s[1:0]});
      {in0, in1, in4} = 3'b000;
      settle;
      chk({4'h0, addr_hi}, {4'h0, DEF});
      {in0, in1, in4} = (s == 1) ? 3'b100 : (s == 2) ? 3'b010 : 3'b001;
      settle;
      chk({4'h0, addr_hi}, 8'h03);
    end
    u_host_model.wr(ALT, 8'h01);
    in0 = 1'b1;
    settle;
    chk({4'h0, addr_hi}, {4'h0, DEF});
    // Lockout with a low rail, then disabled
    rail_low = 1'b1;
    u_host_model.wr(PM, 8'h00);
    settle;
    chk({6'h00, comp_on, lockout}, 8'h03);
    u_host_model.wr(PM, 8'h80);
    settle;
    chk({6'h00, comp_on, lockout}, 8'h00);
    // Reload edge ignored while disabled, honoured once enabled
    gp0_in = 1'b1;
    u_host_model.wr(PM, 8'h00);
    gp0 = 1'b1;
    settle;
    chk({7'h00, seen_reload}, 8'h00);
    gp0 = 1'b0;
    u_host_model.wr(PM, 8'h01);
    gp0 = 1'b1;
    settle;
    chk({7'h00, seen_reload}, 8'h01);
    // Ramp with A good masked and A overcurrent on the long holdoff
    u_host_model.wr(PM, 8'h26);
    {pg_a, pg_b} = 2'b11;
    settle;
    {ramp_a, ramp_b, oc_a, oc_b} = 4'hF;
    settle;
    {pg_a, pg_b} = 2'b00;
    settle;
    chk({4'h0, good_a, good_b, ev_a, ev_b}, 8'h09);
    {ramp_a, ramp_b} = 2'b00;
    cnt = 0;
    while (ev_a !== 1'b1 && cnt < 200)
    begin
      @(negedge clk);
      cnt++;
    end
    chk({7'h00, cnt >= HL && cnt <= HL + 4}, 8'h01);
    chk({7'h00, good_a}, 8'h00);
    // Short holdoff on A and middle one on B, both from one ramp end
    u_host_model.wr(PM, 8'h12);
    {ramp_a, ramp_b} = 2'b11;
    settle;
    chk({6'h00, ev_a, ev_b}, 8'h00);
    {ramp_a, ramp_b} = 2'b00;
    cnt = 0;
    while (ev_a !== 1'b1 && cnt < 1100)
    begin
      @(negedge clk);
      cnt++;
    end
    chk({6'h00, cnt >= HS && cnt <= HS + 4, ev_b}, 8'h02);
    while (ev_b !== 1'b1 && cnt < 1100)
    begin
      @(negedge clk);
      cnt++;
    end
    chk({7'h00, cnt >= HM && cnt <= HM + 4}, 8'h01);
    final_report;
  end
endmodule : buck_app_config_bank_test
